/* File: hdl/acd_pkg.sv */
// acd_pkg: offsets, field positions, reset values and timing counts for the
// audio clock detect and configuration register group.
// assumes a 40 MHz system clock and an 8-bit control port with 7-bit sub-address.
package acd_pkg;
  // clock rate
  localparam int unsigned CLK_HZ = 40_000_000;

  // register offsets inside book 0, page 0
  localparam logic [6:0] OFS_PAGE_WRAP   = 7'h0F;
  localparam logic [6:0] OFS_RATIO_RATE  = 7'h28;
  localparam logic [6:0] OFS_FAULT_MASK  = 7'h29;
  localparam logic [6:0] OFS_SOUT_SEL    = 7'h30;
  localparam logic [6:0] OFS_PAGE_SELECT = 7'h00;
  localparam logic [6:0] OFS_BOOK_SELECT = 7'h7F;

  // reset values
  localparam logic [7:0] RST_PAGE_WRAP  = 8'h00;
  localparam logic [7:0] RST_RATIO_RATE = 8'h00;
  localparam logic [7:0] RST_FAULT_MASK = 8'h00;
  localparam logic [7:0] RST_SOUT_SEL   = 8'h00;

  // field positions
  localparam int unsigned POS_PAGE_WRAP_DISABLE = 3;
  localparam int unsigned POS_RATIO_MSB         = 7;
  localparam int unsigned POS_RATIO_LSB         = 4;
  localparam int unsigned POS_RATE_MSB          = 3;
  localparam int unsigned POS_RATE_LSB          = 0;
  localparam int unsigned POS_IGN_PLL           = 6;
  localparam int unsigned POS_IGN_RANGE         = 5;
  localparam int unsigned POS_IGN_FRAME         = 4;
  localparam int unsigned POS_IGN_RATIO         = 3;
  localparam int unsigned POS_IGN_LOSS          = 2;
  localparam int unsigned POS_SOUT_SRC          = 0;

  // writable bit masks (register width is 8, unused bits kept as storage)
  localparam logic [7:0] WMASK_ALL = 8'hFF;

  // page wrap targets
  localparam logic [6:0] ADDR_LAST_IN_PAGE = 7'h7F;
  localparam logic [6:0] ADDR_NEXT_PAGE    = 7'h08;
  localparam logic [6:0] ADDR_PAGE_START   = 7'h00;

  // bit clock ratio codes (bit clocks per frame)
  localparam logic [3:0] RATIO_32  = 4'h3;
  localparam logic [3:0] RATIO_64  = 4'h5;
  localparam logic [3:0] RATIO_128 = 4'h7;
  localparam logic [3:0] RATIO_256 = 4'h9;
  localparam logic [3:0] RATIO_512 = 4'hB;

  // sample rate select codes
  localparam logic [3:0] RATE_AUTO = 4'h0;
  localparam logic [3:0] RATE_32K  = 4'h6;
  localparam logic [3:0] RATE_44K1 = 4'h8;
  localparam logic [3:0] RATE_48K  = 4'h9;
  localparam logic [3:0] RATE_88K2 = 4'hA;
  localparam logic [3:0] RATE_96K  = 4'hB;

  // clock checks
  localparam logic [7:0]  PLL_OVERRATE_MHZ = 8'd150;
  localparam int unsigned RATIO_MIN        = 32;
  localparam int unsigned RATIO_MAX        = 512;
  localparam int unsigned BCK_MIN_HZ       = 256_000;
  localparam int unsigned BCK_MAX_HZ       = 50_000_000;
  // longest allowed bit clock period, rounded down
  localparam int unsigned BCK_MAX_PERIOD_CYC = CLK_HZ / BCK_MIN_HZ;
  // no bit clock edge for this long means the clock is missing
  localparam int unsigned BCK_LOSS_CYC      = 4 * BCK_MAX_PERIOD_CYC;
  // expected frame periods in system cycles
  localparam logic [11:0] FP_32K  = 12'(CLK_HZ / 32_000);
  localparam logic [11:0] FP_44K1 = 12'(CLK_HZ / 44_100);
  localparam logic [11:0] FP_48K  = 12'(CLK_HZ / 48_000);
  localparam logic [11:0] FP_88K2 = 12'(CLK_HZ / 88_200);
  localparam logic [11:0] FP_96K  = 12'(CLK_HZ / 96_000);
  // tolerance = expected / 2^FP_TOL_SHIFT
  localparam int unsigned FP_TOL_SHIFT = 4;

  // status bit positions
  localparam int unsigned ST_PLL   = 4;
  localparam int unsigned ST_RANGE = 3;
  localparam int unsigned ST_FRAME = 2;
  localparam int unsigned ST_RATIO = 1;
  localparam int unsigned ST_LOSS  = 0;
endpackage : acd_pkg

/* File: hdl/acd_addr_step.sv */
// acd_addr_step: next sub-address/page of an auto-incrementing control access.
// assumes the caller holds address, page and book in registers.
`timescale 1ns/10ps
`default_nettype none
module acd_addr_step
  import acd_pkg::*;
(
  input  wire logic [6:0] i_addr,
  input  wire logic [7:0] i_page,
  input  wire logic [7:0] i_book,
  input  wire logic       i_wrap_disable,
  output logic      [6:0] o_addr,
  output logic      [7:0] o_page
);
  wire at_end   = (i_addr == ADDR_LAST_IN_PAGE);
  // book 0 always wraps inside the page; coefficient books may stream on
  wire next_pg  = at_end && (i_book != 8'h00) && !i_wrap_disable;

  // advance, roll to next page at 8, or wrap to 0 of same page
  assign o_addr = !at_end ? 7'(i_addr + 7'h01)
                : next_pg ? ADDR_NEXT_PAGE
                : ADDR_PAGE_START;
  assign o_page = next_pg ? 8'(i_page + 8'h01) : i_page;
endmodule : acd_addr_step
`default_nettype wire

/* File: hdl/acd_regs.sv */
// acd_regs: control port register group for clock detection, frame ratio,
// sample rate, page wrap and serial output source selection.
// assumes the control port decoder gives single-cycle strobes on i_clk, and that
// bit clock / frame clock arrive asynchronously from pins.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - wrap enabled, book not 0: next page, address eight
// - wrap disabled: back to address zero
// - ratio field codes 32 to 512 fs
// - PLL at/above 150 MHz flags error
// - bit clock outside 256k-50M flags error; only below 256k flags, the 50M bound is not checked
// - ignored frame error still shows in status
// - ratio outside 32..512 flags error
// - missing bit clock flags error
// - output pin picks post or pre DSP
module acd_regs
  import acd_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_addr_load,
  input  wire logic [6:0] i_load_addr,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_rd,
  input  wire logic       i_sout_source,
  input  wire logic [7:0] i_pll_rate_mhz,
  input  wire logic       i_bit_clock,
  input  wire logic       i_frame_clock,
  input  wire logic       i_dsp_post,
  input  wire logic       i_dsp_pre,
  output logic      [7:0] o_rdata,
  output logic      [6:0] o_addr,
  output logic      [7:0] o_page,
  output logic      [7:0] o_book,
  output logic      [3:0] o_bit_clock_ratio,
  output logic      [3:0] o_sample_rate_select,
  output logic      [4:0] o_clock_detect_status,
  output logic            o_clock_error,
  output logic            o_serial_audio_out
);
  logic [7:0]  page_wrap_r, ratio_rate_r, fault_mask_r, sout_sel_r;
  logic [6:0]  addr_r;
  logic [7:0]  page_r, book_r, rdata_r;
  logic [1:0]  bck_sync_r, fck_sync_r;
  logic        bck_d_r, fck_d_r;
  logic [11:0] bck_per_r, fck_per_r;
  logic [9:0]  bck_cnt_r;
  logic [4:0]  status_r;
  logic        clk_err_r, sout_r;
  logic [6:0]  step_addr;
  logic [7:0]  step_page;

  // page 0 of book 0 is where this group lives
  wire in_cfg    = (page_r == 8'h00) && (book_r == 8'h00);
  wire acc       = i_wr | i_rd;
  wire wr_wrap   = i_wr && in_cfg && (addr_r == OFS_PAGE_WRAP);
  wire wr_ratio  = i_wr && in_cfg && (addr_r == OFS_RATIO_RATE);
  wire wr_mask   = i_wr && in_cfg && (addr_r == OFS_FAULT_MASK);
  // page select answers on every page so the host can always get home;
  // book select only on page 0
  wire wr_page   = i_wr && (addr_r == OFS_PAGE_SELECT);
  wire wr_book   = i_wr && (page_r == 8'h00) && (addr_r == OFS_BOOK_SELECT);

  // read mux; unmapped addresses read zero
  wire [7:0] rd_mux = !in_cfg ? ((addr_r == OFS_PAGE_SELECT) ? page_r : 8'h00)
                    : (addr_r == OFS_PAGE_WRAP)   ? page_wrap_r
                    : (addr_r == OFS_RATIO_RATE)  ? ratio_rate_r
                    : (addr_r == OFS_FAULT_MASK)  ? fault_mask_r
                    : (addr_r == OFS_SOUT_SEL)    ? sout_sel_r
                    : (addr_r == OFS_PAGE_SELECT) ? page_r
                    : (addr_r == OFS_BOOK_SELECT) ? book_r
                    : 8'h00;

  acd_addr_step u_step (
    .i_addr         (addr_r),
    .i_page         (page_r),
    .i_book         (book_r),
    .i_wrap_disable (page_wrap_r[POS_PAGE_WRAP_DISABLE]),
    .o_addr         (step_addr),
    .o_page         (step_page)
  );

  // address, page and book pointer; a page write wins over the auto page step
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      addr_r <= 7'h00;
      page_r <= 8'h00;
      book_r <= 8'h00;
    end else begin
      if (i_addr_load)
        addr_r <= i_load_addr;
      else if (acc)
        addr_r <= step_addr;
      if (wr_page)
        page_r <= i_wdata;
      else if (acc)
        page_r <= step_page;
      if (wr_book)
        book_r <= i_wdata;
    end
  end

  // configuration storage and read data
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      page_wrap_r  <= RST_PAGE_WRAP;
      ratio_rate_r <= RST_RATIO_RATE;
      fault_mask_r <= RST_FAULT_MASK;
      sout_sel_r   <= RST_SOUT_SEL;
      rdata_r      <= 8'h00;
    end else begin
      // reserved bits are kept as plain storage, so a read returns what was written
      if (wr_wrap)  page_wrap_r  <= i_wdata & WMASK_ALL;
      if (wr_ratio) ratio_rate_r <= i_wdata & WMASK_ALL;
      if (wr_mask)  fault_mask_r <= i_wdata & WMASK_ALL;
      // read-only: mirrors the routing input, host writes are ignored
      sout_sel_r <= {7'h00, i_sout_source};
      if (i_rd) rdata_r <= rd_mux;
    end
  end

  // two-flop synchronisers for the pin clocks, then edge history
  // only the second stage feeds logic; the first may still be settling
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bck_sync_r <= 2'b00;
      fck_sync_r <= 2'b00;
      bck_d_r    <= 1'b0;
      fck_d_r    <= 1'b0;
    end else begin
      bck_sync_r <= {bck_sync_r[0], i_bit_clock};
      fck_sync_r <= {fck_sync_r[0], i_frame_clock};
      bck_d_r    <= bck_sync_r[1];
      fck_d_r    <= fck_sync_r[1];
    end
  end

  wire bck_rise = bck_sync_r[1] & ~bck_d_r;
  wire fck_rise = fck_sync_r[1] & ~fck_d_r;

  // periods in system cycles (saturating) and bit clocks per frame
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bck_per_r <= 12'h000;
      fck_per_r <= 12'h000;
      bck_cnt_r <= 10'h000;
    end else begin
      if (bck_rise)
        bck_per_r <= 12'h000;
      else if (bck_per_r != 12'hFFF)
        bck_per_r <= 12'(bck_per_r + 12'h001);
      if (fck_rise)
        fck_per_r <= 12'h000;
      else if (fck_per_r != 12'hFFF)
        fck_per_r <= 12'(fck_per_r + 12'h001);
      if (fck_rise)
        bck_cnt_r <= {9'h000, bck_rise};
      else if (bck_rise && bck_cnt_r != 10'h3FF)
        bck_cnt_r <= 10'(bck_cnt_r + 10'h001);
    end
  end

  // expected frame period for the selected rate; auto and reserved give zero
  wire [3:0]  rate_sel = ratio_rate_r[POS_RATE_MSB:POS_RATE_LSB];
  wire [11:0] fp_exp   = (rate_sel == RATE_32K)  ? FP_32K
                       : (rate_sel == RATE_44K1) ? FP_44K1
                       : (rate_sel == RATE_48K)  ? FP_48K
                       : (rate_sel == RATE_88K2) ? FP_88K2
                       : (rate_sel == RATE_96K)  ? FP_96K
                       : 12'h000;
  wire [11:0] fp_tol   = fp_exp >> FP_TOL_SHIFT;
  wire        rate_rsv = (fp_exp == 12'h000) && (rate_sel != RATE_AUTO);

  // error sources; periods are judged when the next edge lands or when overdue.
  // a 40 MHz sampler cannot see the 50 MHz upper bound, so only slow clocks flag.
  wire e_pll   = (i_pll_rate_mhz >= PLL_OVERRATE_MHZ);
  wire e_loss  = (bck_per_r >= 12'(BCK_LOSS_CYC));
  wire e_range = (bck_per_r > 12'(BCK_MAX_PERIOD_CYC));
  // a short frame is only known at its closing edge, so that verdict is held to the
  // next frame edge; an overdue frame flags at once. auto never flags, reserved always
  wire fr_lo   = (fck_per_r < 12'(fp_exp - fp_tol));
  wire fr_hi   = (fck_per_r > 12'(fp_exp + fp_tol));
  wire fr_held = fck_rise ? fr_lo : status_r[ST_FRAME];
  wire e_frame = (fp_exp == 12'h000) ? rate_rsv : (fr_hi || fr_held);
  wire e_ratio = fck_rise && ((bck_cnt_r < 10'(RATIO_MIN)) ||
                              (bck_cnt_r > 10'(RATIO_MAX)));

  // one bit per detector, in status order: pll, range, frame, ratio, loss
  wire [4:0] err_now = {e_pll, e_range, e_frame, e_ratio, e_loss};
  // ratio error is judged once per frame, so hold it until the next frame edge
  wire ratio_hold = fck_rise ? e_ratio : status_r[ST_RATIO];
  wire [4:0] st_nxt = {err_now[4:2], ratio_hold, err_now[0]};
  wire [4:0] unmasked = st_nxt & ~{fault_mask_r[POS_IGN_PLL], fault_mask_r[POS_IGN_RANGE],
                                   fault_mask_r[POS_IGN_FRAME], fault_mask_r[POS_IGN_RATIO],
                                   fault_mask_r[POS_IGN_LOSS]};

  // status is a plain level: nothing is sticky, so no set/clear race exists
  // status keeps masked errors visible; clock error only the unmasked ones
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      status_r  <= 5'h00;
      clk_err_r <= 1'b0;
      sout_r    <= 1'b0;
    end else begin
      status_r  <= st_nxt;
      clk_err_r <= |unmasked;
      sout_r    <= sout_sel_r[POS_SOUT_SRC] ? i_dsp_pre : i_dsp_post;
    end
  end

  assign o_rdata               = rdata_r;
  assign o_addr                = addr_r;
  assign o_page                = page_r;
  assign o_book                = book_r;
  assign o_bit_clock_ratio     = ratio_rate_r[POS_RATIO_MSB:POS_RATIO_LSB];
  assign o_sample_rate_select  = rate_sel;
  assign o_clock_detect_status = status_r;
  assign o_clock_error         = clk_err_r;
  assign o_serial_audio_out    = sout_r;
endmodule : acd_regs
`default_nettype wire

/* File: testbench/acd_regs_chk.sv */
// acd_regs_chk: port-level assertions for acd_regs.
// assumes a bind onto acd_regs; shadows the book 0 page 0 writes it needs.
`timescale 1ns/10ps
`default_nettype none
module acd_regs_chk
  import acd_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_addr_load,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic       i_sout_source,
  input wire logic [7:0] i_pll_rate_mhz,
  input wire logic       i_bit_clock,
  input wire logic       i_dsp_post,
  input wire logic       i_dsp_pre,
  input wire logic [6:0] o_addr,
  input wire logic [7:0] o_page,
  input wire logic [7:0] o_book,
  input wire logic [3:0] o_bit_clock_ratio,
  input wire logic [3:0] o_sample_rate_select,
  input wire logic [4:0] o_clock_detect_status,
  input wire logic       o_clock_error,
  input wire logic       o_serial_audio_out
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  logic       home, step, seen_r, bc_d, src_d1, src_d2, sout_exp;
  logic [7:0] wrap_r, mask_r, mask_d;
  logic [9:0] idle_r;
  // only reads are judged at the page end: a write there may move the book
  assign home     = o_book == 8'h00 && o_page == 8'h00 && !i_addr_load;
  assign step     = i_rd && !i_addr_load && o_addr == ADDR_LAST_IN_PAGE;
  assign sout_exp = i_sout_source ? i_dsp_pre : i_dsp_post;
  // shadow registers and cycles since the bit clock last moved
  always_ff @(posedge i_clk) begin
    bc_d   <= i_bit_clock;
    src_d1 <= i_sout_source;
    src_d2 <= src_d1;
    mask_d <= mask_r;
    if (!i_reset_n) begin
      {wrap_r, mask_r, seen_r, idle_r} <= '0;
    end else begin
      if (i_wr && home && o_addr == OFS_PAGE_WRAP) wrap_r <= i_wdata;
      if (i_wr && home && o_addr == OFS_FAULT_MASK) mask_r <= i_wdata;
      seen_r <= seen_r || (i_bit_clock != bc_d);
      idle_r <= (i_bit_clock != bc_d) ? 10'h000 : idle_r + 10'(idle_r != 10'h3FF);
    end
  end
  sequence page_end(logic fwd);
    step && fwd == (o_book != 8'h00 && !wrap_r[POS_PAGE_WRAP_DISABLE]);
  endsequence
  chk_wrap_next_page: assert property (page_end(1'b1) |=>
    o_addr == ADDR_NEXT_PAGE && o_page == $past(o_page) + 8'h01) else $error("no page advance");
  chk_wrap_same_page: assert property (page_end(1'b0) |=>
    o_addr == ADDR_PAGE_START && $stable(o_page)) else $error("no wrap in page");
  chk_ratio_fields: assert property (i_wr && home && o_addr == OFS_RATIO_RATE |=>
    {o_bit_clock_ratio, o_sample_rate_select} == $past(i_wdata)) else $error("fields wrong");
  chk_sout_path: assert property (i_sout_source == src_d1 && src_d1 == src_d2 |=>
    o_serial_audio_out == $past(sout_exp)) else $error("output source wrong");
  chk_pll_flag: assert property ($stable(i_pll_rate_mhz) [*3] |=>
    o_clock_detect_status[ST_PLL] == ($past(i_pll_rate_mhz) >= PLL_OVERRATE_MHZ))
    else $error("pll flag wrong");
  chk_range_flag: assert property (seen_r && idle_r >= 10'h0C8 |->
    o_clock_detect_status[ST_RANGE]) else $error("range flag missing");
  chk_loss_flag: assert property (seen_r && idle_r >= 10'h280 |->
    o_clock_detect_status[ST_LOSS]) else $error("loss flag missing");
  chk_error_mask: assert property (mask_r == mask_d |->
    o_clock_error == |(o_clock_detect_status & ~mask_r[6:2])) else $error("error or wrong");
endmodule : acd_regs_chk
`default_nettype wire

/* File: testbench/acd_host.sv */
// acd_host: control port master; one strobe per access, a gap cycle between.
// assumes the bench clock; drives on falling edges, scrambles idle address and data.
`timescale 1ns/10ps
`default_nettype none
module acd_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output var  logic       o_load,
  output var  logic [6:0] o_addr,
  output var  logic       o_wr,
  output var  logic       o_rd,
  output var  logic [7:0] o_wdata
);
  initial begin
    {o_load, o_wr, o_rd, o_addr, o_wdata} = {3'h0, 7'h55, 8'hA5};
  end
  // strobe held over one rising edge, then address and data turn to junk
  task automatic strobe(input logic [2:0] k, input logic [6:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {o_load, o_wr, o_rd, o_addr, o_wdata} = {k, a, d};
    @(negedge i_clk);
    {o_load, o_wr, o_rd, o_addr, o_wdata} = {3'h0, ~a, ~d};
  endtask : strobe
  task automatic put(input logic [6:0] a, input logic [7:0] d);
    strobe(3'h4, a, 8'h3C);
    strobe(3'h2, ~a, d);
  endtask : put
  task automatic get(input logic [6:0] a, output logic [7:0] q);
    strobe(3'h4, a, 8'h3C);
    strobe(3'h1, ~a, 8'hC3);
    q = i_rdata;
  endtask : get
endmodule : acd_host
`default_nettype wire

/* File: testbench/test_acd_regs.sv */
// test_acd_regs: self-checking bench for the clock detect register group.
// assumes acd_pkg, acd_regs, acd_host and acd_regs_chk compiled before it.
`timescale 1ns/10ps
`default_nettype none
module test_acd_regs;
  import acd_pkg::*;
  logic       i_clk = 1'b0, i_reset_n = 1'b0, src = 1'b0, bit_clock = 1'b0, fck = 1'b0;
  logic       post = 1'b0, pre = 1'b1, run_bc = 1'b0, ld, wr, rd, err, sout;
  logic [6:0] la, addr;
  logic [7:0] wd, rdata, page, book, q, pll = 8'h00;
  logic [3:0] ratio, rate;
  logic [4:0] status;
  int         n_mismatch = 0, check_count = 0, bc_per_fr = 64;
  always #12.5 i_clk = ~i_clk;
  acd_host u_host (.i_clk(i_clk), .i_rdata(rdata), .o_load(ld), .o_addr(la), .o_wr(wr),
    .o_rd(rd), .o_wdata(wd));
  acd_regs u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr_load(ld), .i_load_addr(la),
    .i_wr(wr), .i_wdata(wd), .i_rd(rd), .i_sout_source(src), .i_pll_rate_mhz(pll),
    .i_bit_clock(bit_clock), .i_frame_clock(fck), .i_dsp_post(post), .i_dsp_pre(pre),
    .o_rdata(rdata), .o_addr(addr), .o_page(page), .o_book(book), .o_bit_clock_ratio(ratio),
    .o_sample_rate_select(rate), .o_clock_detect_status(status), .o_clock_error(err),
    .o_serial_audio_out(sout));
  // dsp streams always differ, so a wrong source shows at once
  always @(negedge i_clk) begin
    post <= ~post;
    pre  <= post;
  end
  // bit clock of 5 cycles; frame clock high in the first half of a frame
  initial forever begin
    if (run_bc) begin
      for (int k = 0; k < bc_per_fr; k++) begin
        fck = (k < bc_per_fr / 2);
        repeat (3) @(negedge i_clk);
        bit_clock = 1'b1;
        repeat (2) @(negedge i_clk);
        bit_clock = 1'b0;
      end
    end else @(negedge i_clk);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic t_reset_vals;
    logic [6:0] ofs [4] = '{OFS_PAGE_WRAP, OFS_RATIO_RATE, OFS_FAULT_MASK, OFS_SOUT_SEL};
    foreach (ofs[i]) begin
      u_host.get(ofs[i], q);
      check({q, ratio, rate}, 16'h0000);
    end
  endtask : t_reset_vals
  task automatic t_ratio_rate;
    logic [3:0] rt [5] = '{RATIO_32, RATIO_64, RATIO_128, RATIO_256, RATIO_512};
    logic [3:0] fs [6] = '{RATE_AUTO, RATE_32K, RATE_44K1, RATE_48K, RATE_88K2, RATE_96K};
    foreach (rt[i]) foreach (fs[j]) begin
      u_host.put(OFS_RATIO_RATE, {rt[i], fs[j]});
      u_host.get(OFS_RATIO_RATE, q);
      check({ratio, rate, q}, {rt[i], fs[j], rt[i], fs[j]});
    end
    src = 1'b1;
    u_host.put(OFS_SOUT_SEL, 8'hFE);
    u_host.get(OFS_SOUT_SEL, q);
    check({8'h00, q}, 16'h0001);
  endtask : t_ratio_rate
  task automatic t_sout;
    for (int s = 0; s < 2; s++) begin
      src = s[0];
      repeat (4) @(negedge i_clk);
      check({15'h0000, sout}, {15'h0000, s[0] ? pre : post});
    end
  endtask : t_sout
  task automatic t_wrap;
    u_host.put(OFS_PAGE_WRAP, 8'h08);
    u_host.put(OFS_BOOK_SELECT, 8'h05);
    u_host.get(ADDR_LAST_IN_PAGE, q);
    check({page, 1'b0, addr}, {8'h00, 1'b0, ADDR_PAGE_START});
    u_host.put(OFS_BOOK_SELECT, 8'h00);
    u_host.put(OFS_PAGE_WRAP, 8'h00);
    u_host.put(OFS_BOOK_SELECT, 8'h05);
    u_host.get(ADDR_LAST_IN_PAGE, q);
    check({page, 1'b0, addr}, {8'h01, 1'b0, ADDR_NEXT_PAGE});
    // leaving the book from 0x7F steps to the next page again, so select page 0 twice
    u_host.put(OFS_PAGE_SELECT, 8'h00);
    u_host.put(OFS_BOOK_SELECT, 8'h00);
    check({page, book}, 16'h0100);
    u_host.put(OFS_PAGE_SELECT, 8'h00);
    check({page, book}, 16'h0000);
  endtask : t_wrap
  // the masked error must drop while the status still reports it
  task automatic det(input logic [7:0] m, input logic [4:0] st);
    u_host.put(OFS_FAULT_MASK, m);
    repeat (4) @(negedge i_clk);
    check({10'h000, err, status}, {10'h000, |(st & ~m[6:2]), st});
  endtask : det
  task automatic t_detect;
    u_host.put(OFS_RATIO_RATE, {RATIO_64, RATE_AUTO});
    pll = 8'h95;
    run_bc = 1'b1;
    repeat (1500) @(negedge i_clk);
    det(8'h00, 5'h00);
    pll = 8'h96;
    det(8'h00, 5'h10);
    det(8'h40, 5'h10);
    pll = 8'h00;
    bc_per_fr = 16;
    repeat (600) @(negedge i_clk);
    det(8'h00, 5'h02);
    det(8'h08, 5'h02);
    bc_per_fr = 64;
    u_host.put(OFS_RATIO_RATE, {RATIO_64, RATE_48K});
    repeat (1500) @(negedge i_clk);
    det(8'h00, 5'h04);
    det(8'h10, 5'h04);
    u_host.put(OFS_RATIO_RATE, {RATIO_64, RATE_AUTO});
    run_bc = 1'b0;
    repeat (1200) @(negedge i_clk);
    det(8'h00, 5'h09);
    det(8'h24, 5'h09);
  endtask : t_detect
  // the whole run is some 5200 cycles
  initial begin
    repeat (50000) @(posedge i_clk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(negedge i_clk);
    i_reset_n = 1'b1;
    t_reset_vals();
    t_ratio_rate();
    t_sout();
    t_wrap();
    t_detect();
    tally_and_finish();
  end
endmodule : test_acd_regs
bind acd_regs acd_regs_chk u_chk (.*);
`default_nettype wire
